// >>> design/tsicm_bank.sv
// Control register and connection memory of a 32-stream slot switch.
// Assumes a synchronous processor port on clk; pins from outside pass two flops.
// Summary of operation
// - Polarity set: indication high while its stream is driven.
// - All-indication set: all 32 pins show indications of their streams.
// - Arm bit enables block loading of connection word high bits.
// - Armed begin: every word gets fill value high, zeros below.
// - Block load starts only on rising edge of begin bit.
// - Drivers high impedance while drive pin and standby both zero.
// - Rising edge of evaluation start bit begins frame evaluation.
// - Evaluation ends on rising edge of the complete flag.
// - Mode field: variable, constant, processor, or high impedance.
// - Bits 13-9 give the source stream number.
// - Bits 8-0 give the source channel number.
// - Control bit 15 resets control, sequencer and outputs like the reset pin; pin synchronisers are not cleared.
// - Bit 14 turns upper 16 pins into indications.
`default_nettype none
module tsicm_bank
   import tsicm_pkg::*;
#(
   parameter int STREAMS = TSICM_STREAMS,
   parameter int CHANNELS = TSICM_CHANNELS
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [15:0] addr,
   input wire logic [15:0] wrData,
   input wire logic writeStrobe,
   input wire logic readStrobe,
   output logic [15:0] rdData,
   output logic rdValid,
   input wire logic outputDrivePin,
   input wire logic frameEvalComplete,
   input wire logic [TSICM_STREAMS-1:0] streamActive,
   input wire logic [TSICM_IDX_W-1:0] lookupIndex,
   output logic [1:0] lookupMode,
   output logic [4:0] lookupStream,
   output logic [8:0] lookupChannel,
   output logic [TSICM_STREAMS-1:0] txIsIndication,
   output logic [TSICM_STREAMS-1:0] txIndication,
   output logic txDriveEnable,
   output logic blockBusy,
   output logic frameEvalRunning,
   output logic softReset
);
   localparam int WORDS = STREAMS * CHANNELS;

   logic [15:0] switchControl;
   logic [15:0] connMem [WORDS];
   logic [TSICM_IDX_W-1:0] fillIndex;
   tsicm_state_t state;
   logic prevBegin, prevEval;
   logic drvMeta, drvSync, doneMeta, doneSync, donePrev;
   logic [TSICM_STREAMS-1:0] actMeta, actSync;

   // Decode
   wire logic isConn = addr[15:14] == TSICM_SPACE_CONN;
   wire logic isRegs = addr[15:14] == TSICM_SPACE_REGS;
   wire logic isCtrl = isRegs && addr[13:10] == TSICM_REG_CTRL;
   wire logic isAlign = isRegs && addr[13:10] == TSICM_REG_ALIGN;
   wire logic [TSICM_IDX_W-1:0] cpuIndex = addr[TSICM_IDX_W-1:0];
   wire logic ctrlWrite = writeStrobe && isCtrl;
   wire logic [15:0] next_control = wrData & TSICM_CTRL_WMASK;
   wire logic beginRise = switchControl[TSICM_B_BEGIN] && !prevBegin;
   wire logic startFill = beginRise && switchControl[TSICM_B_ARM];
   wire logic evalRise = switchControl[TSICM_B_EVAL] && !prevEval;
   wire logic doneRise = doneSync && !donePrev;
   wire logic fillLast = fillIndex == TSICM_IDX_W'(WORDS - 1);
   wire logic [15:0] fillWord = {switchControl[TSICM_B_FILLHI], switchControl[TSICM_B_FILLLO],
                                 14'h0000};
   wire logic [15:0] lookWord = connMem[lookupIndex];
   wire logic polarity = switchControl[TSICM_B_POL];
   wire logic driveOn = drvSync || switchControl[TSICM_B_STBY];
   wire logic [TSICM_STREAMS-1:0] indSense = polarity ? actSync : ~actSync;
   wire logic [TSICM_STREAMS-1:0] upperMask = {{(TSICM_STREAMS/2){1'b1}}, {(TSICM_STREAMS/2){1'b0}}};
   wire logic [TSICM_STREAMS-1:0] next_isInd = switchControl[TSICM_B_ALLIND] ? '1 :
                                   (switchControl[TSICM_B_UPIND] ? upperMask : '0);
   wire logic [15:0] alignWord = {1'b0, doneSync, 14'h0000};
   wire logic [15:0] next_rd = isCtrl ? switchControl : (isConn ? connMem[cpuIndex] :
                               (isAlign ? alignWord : 16'h0000));
   // Software reset acts as an asynchronous clear for one cycle like the pin
   wire logic anyReset = reset || softReset;

   // Pin synchronisers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         drvMeta <= 1'b0;
         drvSync <= 1'b0;
         doneMeta <= 1'b0;
         doneSync <= 1'b0;
         actMeta <= '0;
         actSync <= '0;
      end else begin
         drvMeta <= outputDrivePin;
         drvSync <= drvMeta;
         doneMeta <= frameEvalComplete;
         doneSync <= doneMeta;
         actMeta <= streamActive;
         actSync <= actMeta;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         softReset <= 1'b0;
      end else begin
         softReset <= ctrlWrite && wrData[TSICM_B_SWRST];
      end
   end

   // Control register and sequencer
   always_ff @(posedge clk or posedge anyReset) begin
      if (anyReset) begin
         switchControl <= TSICM_CTRL_RESET;
         prevBegin <= 1'b0;
         prevEval <= 1'b0;
         donePrev <= 1'b0;
         state <= TSICM_IDLE;
         fillIndex <= '0;
      end else begin
         if (ctrlWrite) begin
            switchControl <= next_control;
         end
         prevBegin <= switchControl[TSICM_B_BEGIN];
         prevEval <= switchControl[TSICM_B_EVAL];
         donePrev <= doneSync;
         case (state)
            TSICM_IDLE: begin
               fillIndex <= '0;
               if (startFill) begin
                  state <= TSICM_FILL;
               end else if (evalRise) begin
                  state <= TSICM_EVAL;
               end
            end
            TSICM_FILL: begin
               fillIndex <= fillIndex + 1'b1;
               if (fillLast) begin
                  state <= TSICM_IDLE;
               end
            end
            TSICM_EVAL: begin
               if (doneRise) begin
                  state <= TSICM_IDLE;
               end
            end
            default: state <= TSICM_IDLE;
         endcase
      end
   end

   // Connection memory: block fill owns the port while running
   always_ff @(posedge clk) begin
      if (state == TSICM_FILL) begin
         connMem[fillIndex] <= fillWord;
      end else if (writeStrobe && isConn) begin
         connMem[cpuIndex] <= wrData;
      end
   end

   // Registered outputs
   always_ff @(posedge clk or posedge anyReset) begin
      if (anyReset) begin
         rdData <= 16'h0000;
         rdValid <= 1'b0;
         lookupMode <= TSICM_VARIABLE;
         lookupStream <= '0;
         lookupChannel <= '0;
         txIsIndication <= '0;
         txIndication <= '0;
         txDriveEnable <= 1'b0;
         blockBusy <= 1'b0;
         frameEvalRunning <= 1'b0;
      end else begin
         rdValid <= readStrobe;
         if (readStrobe) begin
            rdData <= next_rd;
         end
         lookupMode <= lookWord[TSICM_MODE_HI:TSICM_MODE_LO];
         lookupStream <= lookWord[TSICM_STRM_HI:TSICM_STRM_LO];
         lookupChannel <= lookWord[TSICM_CHAN_HI:TSICM_CHAN_LO];
         txIsIndication <= next_isInd;
         txIndication <= indSense;
         txDriveEnable <= driveOn;
         blockBusy <= state == TSICM_FILL;
         frameEvalRunning <= state == TSICM_EVAL;
      end
   end
endmodule
`default_nettype wire

// >>> design/tsicm_pkg.sv
// Package for the switch control register and connection memory bank.
// Assumes a 16-bit parallel processor port with a 16-bit address.
`default_nettype none
package tsicm_pkg;
   localparam int TSICM_STREAMS = 32;
   localparam int TSICM_CHANNELS = 512;
   localparam int TSICM_WORDS = TSICM_STREAMS * TSICM_CHANNELS;
   localparam int TSICM_IDX_W = 14;
   // Address decode (upper bits of the processor address)
   localparam logic [1:0] TSICM_SPACE_CONN = 2'h2;
   localparam logic [1:0] TSICM_SPACE_REGS = 2'h1;
   localparam logic [3:0] TSICM_REG_CTRL = 4'h0;
   localparam logic [3:0] TSICM_REG_ALIGN = 4'h1;
   localparam logic [15:0] TSICM_CTRL_RESET = 16'h0000;
   // Bit 15 is a command, not a setting: it acts through the reset pulse and never reads back
   localparam logic [15:0] TSICM_CTRL_WMASK = 16'h73F0;
   // Control bit positions
   localparam int TSICM_B_SWRST = 15;
   localparam int TSICM_B_UPIND = 14;
   localparam int TSICM_B_POL = 13;
   localparam int TSICM_B_ALLIND = 12;
   localparam int TSICM_B_ARM = 9;
   localparam int TSICM_B_FILLHI = 8;
   localparam int TSICM_B_FILLLO = 7;
   localparam int TSICM_B_BEGIN = 6;
   localparam int TSICM_B_STBY = 5;
   localparam int TSICM_B_EVAL = 4;
   localparam int TSICM_B_DONE = 14;
   // Connection word fields
   localparam int TSICM_MODE_HI = 15;
   localparam int TSICM_MODE_LO = 14;
   localparam int TSICM_STRM_HI = 13;
   localparam int TSICM_STRM_LO = 9;
   localparam int TSICM_CHAN_HI = 8;
   localparam int TSICM_CHAN_LO = 0;
   typedef enum logic [1:0] {
      TSICM_VARIABLE = 2'h0,
      TSICM_CONSTANT = 2'h1,
      TSICM_PROCESSOR = 2'h2,
      TSICM_HIGHZ = 2'h3
   } tsicm_mode_t;
   typedef enum logic [1:0] {
      TSICM_IDLE = 2'h0,
      TSICM_FILL = 2'h1,
      TSICM_EVAL = 2'h3
   } tsicm_state_t;
endpackage
`default_nettype wire

// >>> verif/tb_tsi_control_and_connection_memory.sv
// Testbench for the control register and connection memory bank.
// Assumes the processor model and the bound port checker.
`default_nettype none
module tb_tsi_control_and_connection_memory;
   import tsicm_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, reset, writeStrobe, readStrobe, rdValid, outputDrivePin, frameEvalComplete;
   logic txDriveEnable, blockBusy, frameEvalRunning, softReset;
   logic [15:0] addr, wrData, rdData, r, w;
   logic [31:0] streamActive, txIsIndication, txIndication;
   logic [13:0] lookupIndex;
   logic [1:0] lookupMode;
   logic [4:0] lookupStream;
   logic [8:0] lookupChannel;
   int n_errors = 0, check_count = 0, cyc = 0;
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; $display("BAD %0t %h %h", $time, g, e); end end
   tsicm_bank DUT (.*);
   tsicm_cpu cpu (.*);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         n_errors++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic t_ctrl();
      cpu.rd(16'h4000, r);
      `CHK(r, 16'h0000)
      `CHK(rdValid, 1'b1)
      cpu.wr(16'h4000, 16'h7C3F);
      repeat (3) @(negedge clk);
      cpu.rd(16'h4000, r);
      `CHK(r, 16'h7030)
      `CHK(txIsIndication, 32'hFFFFFFFF)
      `CHK(txIndication, streamActive)
      `CHK(txDriveEnable, 1'b1)
      `CHK(frameEvalRunning, 1'b1)
      frameEvalComplete = 1'b1;
      repeat (8) @(negedge clk);
      `CHK(frameEvalRunning, 1'b0)
      cpu.rd(16'h4400, r);
      `CHK(r, 16'h4000)
      cpu.wr(16'h4000, 16'h4000);
      repeat (2) @(negedge clk);
      `CHK(txIsIndication, 32'hFFFF0000)
      `CHK(txIndication, ~streamActive)
      `CHK(txDriveEnable, 1'b0)
      $display("ctrl done");
   endtask
   task automatic t_conn();
      for (int m = 0; m < 4; m++) begin
         w = {2'(m), 5'(m + 17), 9'h1A5 ^ 9'(m)};
         cpu.wr(16'h8000 | 16'(m), w);
         lookupIndex = 14'(m);
         repeat (2) @(negedge clk);
         `CHK(lookupMode, w[15:14])
         `CHK(lookupStream, w[13:9])
         `CHK(lookupChannel, w[8:0])
      end
      $display("conn done");
   endtask
   task automatic t_fill();
      cpu.wr(16'h4000, 16'h0340);
      repeat (4) @(negedge clk);
      `CHK(blockBusy, 1'b1)
      for (int i = 0; i < 17000 && blockBusy; i++)
         @(negedge clk);
      cpu.rd(16'h8002, r);
      `CHK(r, 16'h8000)
      cpu.wr(16'h4000, 16'h0340);
      repeat (4) @(negedge clk);
      `CHK(blockBusy, 1'b0)
      cpu.wr(16'h4000, 16'h0000);
      cpu.wr(16'h4000, 16'h0140);
      repeat (4) @(negedge clk);
      `CHK(blockBusy, 1'b0)
      cpu.wr(16'h4000, 16'h9000);
      cpu.rd(16'h4000, r);
      `CHK(r, 16'h0000)
      $display("fill done");
   endtask
   initial begin
      reset = 1'b1;
      outputDrivePin = 1'b0;
      frameEvalComplete = 1'b0;
      streamActive = 32'hA5C30F1E;
      lookupIndex = 14'h0000;
      repeat (10) @(negedge clk);
      reset = 1'b0;
      t_ctrl();
      t_conn();
      t_fill();
      report_and_stop();
   end
endmodule
`default_nettype wire

// >>> verif/tsicm_bank_asserts.sv
// Port checker for the control and connection memory bank.
// Assumes a bind to every bank instance; one clock domain.
`default_nettype none
module tsicm_bank_asserts
   import tsicm_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [15:0] addr,
   input wire logic [15:0] wrData,
   input wire logic writeStrobe,
   input wire logic [TSICM_STREAMS-1:0] txIsIndication,
   input wire logic txDriveEnable,
   input wire logic blockBusy,
   input wire logic softReset
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Soft reset writes are left out: they clear control one cycle later
   wire logic ctrlWr = writeStrobe && addr[15:10] == 6'h10 && !wrData[15];
   a_all_ind: assert property (ctrlWr && wrData[12] |-> ##2 txIsIndication == 32'hFFFFFFFF)
      else $error("all indication not set");
   a_upper_ind: assert property (ctrlWr && wrData[14] && !wrData[12] |-> ##2 txIsIndication == 32'hFFFF0000)
      else $error("upper indication wrong");
   a_no_ind: assert property (ctrlWr && !wrData[14] && !wrData[12] |-> ##2 txIsIndication == 32'h0)
      else $error("indication without mode");
   a_standby_drive: assert property (ctrlWr && wrData[5] |-> ##2 txDriveEnable)
      else $error("standby did not enable");
   a_fill_cause: assert property ($rose(blockBusy) |-> $past(ctrlWr, 3) && $past(wrData[9], 3) && $past(wrData[6], 3))
      else $error("fill without armed begin");
   a_fill_hold: assert property ($rose(blockBusy) |-> blockBusy [*8])
      else $error("fill ended early");
   a_soft_pulse: assert property (writeStrobe && addr == 16'h4000 && wrData[15] |=> softReset)
      else $error("soft reset missing");
   a_pulse_one: assert property (softReset |=> !softReset)
      else $error("soft reset too long");
endmodule
bind tsicm_bank tsicm_bank_asserts u_chk (.*);
`default_nettype wire

// >>> verif/tsicm_cpu.sv
// Processor model: one-word writes and reads on the bank port.
// Assumes the bank answers a read one cycle after the strobe.
`default_nettype none
module tsicm_cpu (
   input wire logic clk,
   input wire logic [15:0] rdData,
   output logic [15:0] addr = 16'h0000,
   output logic [15:0] wrData = 16'h0000,
   output logic writeStrobe = 1'b0,
   output logic readStrobe = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   // Whole word per access, so begin and fill value never split
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge clk);
      addr = a;
      wrData = d;
      writeStrobe = 1'b1;
      @(negedge clk);
      writeStrobe = 1'b0;
      wrData = ~d;
   endtask
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(negedge clk);
      addr = a;
      readStrobe = 1'b1;
      @(negedge clk);
      readStrobe = 1'b0;
      d = rdData;
   endtask
endmodule
`default_nettype wire
